// File: hw/sbc_mode_pkg.sv
package sbc_mode_pkg;
    // operating modes, binary codes
    typedef enum logic [2:0] {
        MODE_INIT = 3'h0,
        MODE_NORMAL = 3'h1,
        MODE_STOP = 3'h2,
        MODE_SLEEP = 3'h3,
        MODE_RESTART = 3'h4,
        MODE_FAILSAFE = 3'h5
    } sbc_mode_t;
    // requested mode bits carried by a spi write
    localparam logic [1:0] REQ_NORMAL = 2'h0;
    localparam logic [1:0] REQ_STOP = 2'h1;
    localparam logic [1:0] REQ_SLEEP = 2'h2;
    localparam logic [1:0] REQ_RESET = 2'h3;
    localparam logic [1:0] MODE_BITS_RESET = 2'h0;
    localparam int CLK_PERIOD_PS = 5000;
    // times in microseconds
    localparam int RESET_DELAY_US = 10;
    localparam int CONFIG_FILTER_US = 2;
    localparam int LONG_WINDOW_US = 200000;
    localparam int RESET_DELAY_CYCLES = (RESET_DELAY_US * 1000000) / CLK_PERIOD_PS;
    localparam int CONFIG_FILTER_CYCLES = (CONFIG_FILTER_US * 1000000) / CLK_PERIOD_PS;
    localparam longint LONG_WINDOW_CYCLES = (64'd200000 * 64'd1000000) / CLK_PERIOD_PS;
    localparam logic CONFIG_LEVEL_RESET = 1'b0;
endpackage

// File: hw/config_filter.sv
`timescale 1ns/1ps
`default_nettype none
// continuous level filter for the config sense pin
module config_filter
    import sbc_mode_pkg::*;
#(
    parameter int FILTER_CYCLES = CONFIG_FILTER_CYCLES
) (
    input wire logic clk_in, // system clock
    input wire logic sys_rst_in, // sync reset
    input wire logic sense_in, // synchronised pin level
    output logic level_out, // filtered level
    output logic stable_out // level held a full filter time
);
    logic [15:0] count_reg, count_next;
    logic last_reg, last_next;
    logic level_reg, level_next;
    logic stable_reg, stable_next;

    // count cycles of unchanged input
    always_comb begin
        last_next = sense_in;
        count_next = count_reg;
        level_next = level_reg;
        stable_next = stable_reg;
        if (sense_in != last_reg) begin
            count_next = 16'h0000;
            stable_next = 1'b0;
        end else if (count_reg >= 16'(FILTER_CYCLES - 1)) begin
            level_next = sense_in;
            stable_next = 1'b1;
        end else begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            count_reg <= 16'h0000;
            last_reg <= 1'b0;
            level_reg <= 1'b0;
            stable_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            last_reg <= last_next;
            level_reg <= level_next;
            stable_reg <= stable_next;
        end
    end

    assign level_out = level_reg;
    assign stable_out = stable_reg;
endmodule
`default_nettype wire

// File: hw/sbc_mode_state_machine.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - six modes, normal is main mode
// - init after power-up and soft reset
// - init starts watchdog long open window
// - restart holds reset, then normal after delay
// - failsafe: supply off until wake/temp ok
// - stop keeps supply, sleep switches off
// - development mode halts watchdog counter
// - debug pin low in power-up init, before reset rise, selects development
// - mode bits written over spi
// - mode bits cleared passing restart
// - pull-down on sense pin during delay
// - filtered level latched at reset rise
// - relatch each reset while power-on flag
// - unstable sense pin latches zero
// - level one: wd failure gives restart
// - level zero: wd failure gives failsafe
// - ov without enable: flag only
// - ov with enable: flag, fail, mode
// - config bits readable as status
// - configuration held until power down
// - any spi command leaves init
// - no trigger in window gives restart
// - wake events ignored in init
// - stop to sleep rejected, restart
module sbc_mode_state_machine
    import sbc_mode_pkg::*;
#(
    parameter longint LONG_WINDOW = LONG_WINDOW_CYCLES,
    parameter int RESET_DELAY = RESET_DELAY_CYCLES,
    parameter int FILTER_CYCLES = CONFIG_FILTER_CYCLES
) (
    input wire logic clk_in, // 200 mhz clock
    input wire logic sys_rst_in, // power-on reset, sync high
    input wire logic spi_cmd_in, // one-cycle pulse, spi frame done
    input wire logic spi_mode_write_in, // frame writes mode bits
    input wire logic [1:0] spi_mode_in, // requested mode bits
    input wire logic wd_trigger_in, // one-cycle watchdog trigger
    input wire logic wd_fail_in, // one-cycle watchdog failure
    input wire logic wd_fail_count_select_in, // cfg bit, 1 = first failure
    input wire logic overvoltage_reset_enable_in, // ov reset enable bit
    input wire logic overvoltage_in, // main supply overvoltage, async
    input wire logic undervoltage_in, // main supply below reset threshold
    input wire logic wake_in, // can or wake_inputs event pulse
    input wire logic overtemp_in, // overtemperature shutdown level
    input wire logic power_on_flag_in, // power-on flag still set
    input wire logic fail3_debug_pin_in, // debug pin level, async
    input wire logic config_sense_pin_in, // config sense pin level, async
    output logic [2:0] mode_out, // current operating mode
    output logic [1:0] mode_bits_out, // mode bits of control register
    output logic main_supply_en_out, // main supply enable
    output logic reset_output_out, // reset to mcu, low active level
    output logic fail_outputs_out, // fail outputs active
    output logic overvoltage_flag_out, // sticky ov flag
    output logic spi_error_flag_out, // sticky spi error flag
    output logic config_pull_down_out, // weak pull-down enable
    output logic config_pin_level_out, // latched config level
    output logic wd_fail_count_select_out, // cfg bit readback
    output logic development_mode_out, // debug mode latched
    output logic wd_long_window_out, // watchdog in long window
    output logic wd_halt_out // watchdog counter halted
);
    sbc_mode_t mode_reg, mode_next;
    logic [1:0] mode_bits_reg, mode_bits_next;
    logic [47:0] wd_count_reg, wd_count_next;
    logic [31:0] delay_count_reg, delay_count_next;
    logic fail_reg, fail_next;
    logic ov_flag_reg, ov_flag_next;
    logic spi_err_reg, spi_err_next;
    logic cfg_reg, cfg_next;
    logic dev_reg, dev_next;
    logic latched_once_reg, latched_once_next;
    logic wd_fails_reg, wd_fails_next;
    logic reset_high_reg, reset_high_next;
    logic ov_last_reg, ov_last_next;
    logic [2:0] ov_sync_reg, dbg_sync_reg, cfg_sync_reg;
    logic ov_level, dbg_level, cfg_pin_level;
    logic filt_level, filt_stable;
    logic ov_event, wd_failure, delay_done;

    // three-stage synchronisers for pin inputs
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ov_sync_reg <= 3'h0;
            dbg_sync_reg <= 3'h7;
            cfg_sync_reg <= 3'h0;
        end else begin
            ov_sync_reg <= {ov_sync_reg[1:0], overvoltage_in};
            dbg_sync_reg <= {dbg_sync_reg[1:0], fail3_debug_pin_in};
            cfg_sync_reg <= {cfg_sync_reg[1:0], config_sense_pin_in};
        end
    end

    // accept a change once stage two and three agree
    logic ov_hold_reg, dbg_hold_reg, cfg_hold_reg;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ov_hold_reg <= 1'b0;
            dbg_hold_reg <= 1'b1;
            cfg_hold_reg <= 1'b0;
        end else begin
            if (ov_sync_reg[1] == ov_sync_reg[2]) ov_hold_reg <= ov_sync_reg[2];
            if (dbg_sync_reg[1] == dbg_sync_reg[2]) dbg_hold_reg <= dbg_sync_reg[2];
            if (cfg_sync_reg[1] == cfg_sync_reg[2]) cfg_hold_reg <= cfg_sync_reg[2];
        end
    end
    assign ov_level = ov_hold_reg;
    assign dbg_level = dbg_hold_reg;
    assign cfg_pin_level = cfg_hold_reg;

    // continuous filter on the sense pin
    config_filter #(
        .FILTER_CYCLES(FILTER_CYCLES)
    ) u_filter (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .sense_in(cfg_pin_level),
        .level_out(filt_level),
        .stable_out(filt_stable)
    );

    assign ov_event = ov_level && !ov_last_reg;
    assign delay_done = (delay_count_reg >= 32'(RESET_DELAY - 1));
    assign wd_failure = (wd_fail_in && !dev_reg) || (mode_reg == MODE_INIT && !dev_reg
        && wd_count_reg >= 48'(LONG_WINDOW - 1));

    // mode, failure and configuration next state
    always_comb begin
        mode_next = mode_reg;
        mode_bits_next = mode_bits_reg;
        wd_count_next = wd_count_reg;
        delay_count_next = delay_count_reg;
        fail_next = fail_reg;
        ov_flag_next = ov_flag_reg || ov_event; // flag set always
        spi_err_next = spi_err_reg;
        cfg_next = cfg_reg;
        dev_next = dev_reg;
        latched_once_next = latched_once_reg;
        wd_fails_next = wd_fails_reg;
        reset_high_next = reset_high_reg;
        ov_last_next = ov_level;
        // long window counts in init; halted in development
        if (mode_reg == MODE_INIT && !dev_reg && !wd_trigger_in) begin
            wd_count_next = wd_count_reg + 48'h1;
        end else begin
            wd_count_next = 48'h0;
        end
        if (mode_reg == MODE_INIT && !latched_once_reg) begin
            dev_next = !dbg_level;
        end
        case (mode_reg)
            MODE_INIT: begin
                if (spi_cmd_in) begin
                    mode_next = MODE_NORMAL;
                end
                if (wd_failure) begin
                    mode_next = MODE_RESTART;
                end
                // reset held low for the delay, sense pin pulled down
                if (!reset_high_reg) begin
                    if (delay_done) begin
                        delay_count_next = 32'h0;
                    end else begin
                        delay_count_next = delay_count_reg + 32'h1;
                    end
                end
            end
            MODE_NORMAL, MODE_STOP: begin
                if (spi_cmd_in && spi_mode_write_in) begin
                    mode_bits_next = spi_mode_in;
                    case (spi_mode_in)
                        REQ_STOP: mode_next = MODE_STOP;
                        REQ_SLEEP: begin
                            if (mode_reg == MODE_STOP) begin
                                spi_err_next = 1'b1;
                                mode_next = MODE_RESTART;
                            end else begin
                                mode_next = MODE_SLEEP;
                            end
                        end
                        REQ_RESET: mode_next = MODE_INIT;
                        default: mode_next = MODE_NORMAL;
                    endcase
                end
                if (undervoltage_in) begin
                    mode_next = MODE_RESTART;
                end
            end
            MODE_SLEEP: begin
                if (wake_in) mode_next = MODE_RESTART;
            end
            MODE_FAILSAFE: begin
                // leave on wake or temperature release
                if (wake_in || !overtemp_in) mode_next = MODE_RESTART;
            end
            MODE_RESTART: begin
                mode_bits_next = MODE_BITS_RESET;
                // back to normal after delay, failure gone
                if (undervoltage_in) begin
                    delay_count_next = 32'h0;
                end else if (delay_done) begin
                    mode_next = MODE_NORMAL;
                    delay_count_next = 32'h0;
                end else begin
                    delay_count_next = delay_count_reg + 32'h1;
                end
            end
            default: mode_next = MODE_INIT;
        endcase
        if (wd_failure && mode_reg != MODE_INIT && mode_reg != MODE_SLEEP
                && mode_reg != MODE_FAILSAFE) begin
            wd_fails_next = 1'b1;
            if (wd_fail_count_select_in || wd_fails_reg) begin
                fail_next = 1'b1;
                mode_next = cfg_reg ? MODE_RESTART : MODE_FAILSAFE;
            end else begin
                mode_next = MODE_RESTART;
            end
        end
        if (ov_event && overvoltage_reset_enable_in) begin
            fail_next = 1'b1;
            mode_next = cfg_reg ? MODE_RESTART : MODE_FAILSAFE;
        end
        // every mode change starts the delay count afresh
        if (mode_next != mode_reg) begin
            delay_count_next = 32'h0;
        end
        // bits read back cleared while restarting
        if (mode_next == MODE_RESTART) begin
            mode_bits_next = MODE_BITS_RESET;
        end
        // reset high only outside restart, init after its delay
        reset_high_next = (mode_next != MODE_RESTART) && (mode_next != MODE_INIT
            || (mode_reg == MODE_INIT && (reset_high_reg || delay_done)));
        if (mode_next == MODE_SLEEP || mode_next == MODE_FAILSAFE) begin
            reset_high_next = 1'b0;
        end
        if (reset_high_next && !reset_high_reg && (!latched_once_reg || power_on_flag_in)) begin
            cfg_next = filt_stable ? filt_level : 1'b0;
            latched_once_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_reg <= MODE_INIT;
            mode_bits_reg <= MODE_BITS_RESET;
            wd_count_reg <= 48'h0;
            delay_count_reg <= 32'h0;
            fail_reg <= 1'b0;
            ov_flag_reg <= 1'b0;
            spi_err_reg <= 1'b0;
            cfg_reg <= CONFIG_LEVEL_RESET;
            dev_reg <= 1'b0;
            latched_once_reg <= 1'b0;
            wd_fails_reg <= 1'b0;
            reset_high_reg <= 1'b0;
            ov_last_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            mode_bits_reg <= mode_bits_next;
            wd_count_reg <= wd_count_next;
            delay_count_reg <= delay_count_next;
            fail_reg <= fail_next;
            ov_flag_reg <= ov_flag_next;
            spi_err_reg <= spi_err_next;
            cfg_reg <= cfg_next;
            dev_reg <= dev_next;
            latched_once_reg <= latched_once_next;
            wd_fails_reg <= wd_fails_next;
            reset_high_reg <= reset_high_next;
            ov_last_reg <= ov_last_next;
        end
    end

    assign mode_out = mode_reg;
    assign mode_bits_out = mode_bits_reg;
    assign main_supply_en_out = (mode_reg != MODE_SLEEP) && (mode_reg != MODE_FAILSAFE);
    assign reset_output_out = reset_high_reg;
    assign fail_outputs_out = fail_reg;
    assign overvoltage_flag_out = ov_flag_reg;
    assign spi_error_flag_out = spi_err_reg;
    assign config_pull_down_out = !reset_high_reg && (!latched_once_reg || power_on_flag_in);
    assign config_pin_level_out = cfg_reg;
    assign wd_fail_count_select_out = wd_fail_count_select_in;
    assign development_mode_out = dev_reg;
    assign wd_long_window_out = (mode_reg == MODE_INIT);
    assign wd_halt_out = dev_reg;
endmodule
`default_nettype wire

// File: tb/sbc_mode_chk.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checker for the mode sequencer
module sbc_mode_chk
    import sbc_mode_pkg::*;
#(
    parameter int RESET_DELAY = RESET_DELAY_CYCLES
) (
    input wire logic clk_in, // clock
    input wire logic sys_rst_in, // reset
    input wire logic spi_cmd_in, // frame done
    input wire logic spi_mode_write_in, // mode write
    input wire logic [1:0] spi_mode_in, // mode asked
    input wire logic wd_fail_in, // wd failure
    input wire logic wd_fail_count_select_in, // fail count
    input wire logic overvoltage_reset_enable_in, // ov enable
    input wire logic wake_in, // wake
    input wire logic overtemp_in, // overtemp
    input wire logic [2:0] mode_out, // mode
    input wire logic [1:0] mode_bits_out, // mode bits
    input wire logic main_supply_en_out, // supply
    input wire logic reset_output_out, // mcu reset
    input wire logic fail_outputs_out, // fail out
    input wire logic overvoltage_flag_out, // ov flag
    input wire logic spi_error_flag_out, // spi error
    input wire logic config_pin_level_out, // config
    input wire logic development_mode_out, // debug mode
    input wire logic wd_halt_out // wd halted
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    int restart_cnt;
    // cycles spent in restart
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || mode_out != MODE_RESTART) begin
            restart_cnt <= 0;
        end else begin
            restart_cnt <= restart_cnt + 1;
        end
    end
    init_exit_a:
        assert property (mode_out == MODE_INIT && spi_cmd_in |=> mode_out == MODE_NORMAL)
        else $error("command in init did not reach normal");
    stop_sleep_a:
        assert property (mode_out == MODE_STOP && spi_cmd_in && spi_mode_write_in
            && spi_mode_in == REQ_SLEEP |=> mode_out == MODE_RESTART && spi_error_flag_out)
        else $error("stop to sleep not refused");
    restart_hold_a:
        assert property (mode_out == MODE_RESTART |-> !reset_output_out
            && mode_bits_out == MODE_BITS_RESET)
        else $error("restart without reset or clear bits");
    restart_len_a:
        assert property (restart_cnt <= RESET_DELAY + 2)
        else $error("restart lasted too long");
    supply_mode_a:
        assert property (main_supply_en_out == !(mode_out inside {MODE_SLEEP, MODE_FAILSAFE}))
        else $error("supply enable wrong for mode");
    wd_fail_a:
        assert property (mode_out == MODE_NORMAL && wd_fail_in && wd_fail_count_select_in
            && !development_mode_out
            |=> fail_outputs_out
            && mode_out == (config_pin_level_out ? MODE_RESTART : MODE_FAILSAFE))
        else $error("watchdog failure reaction wrong");
    ov_off_a:
        assert property ($rose(overvoltage_flag_out) && !overvoltage_reset_enable_in
            |-> $stable(mode_out) && $stable(fail_outputs_out) ##1 $stable(mode_out))
        else $error("overvoltage acted without enable");
    ov_on_a:
        assert property ($rose(overvoltage_flag_out) && overvoltage_reset_enable_in
            |-> ##[0:1] fail_outputs_out
            && mode_out == (config_pin_level_out ? MODE_RESTART : MODE_FAILSAFE))
        else $error("overvoltage reaction wrong");
    failsafe_keep_a:
        assert property (mode_out == MODE_FAILSAFE && !wake_in && overtemp_in
            |=> mode_out == MODE_FAILSAFE)
        else $error("failsafe left without cause");
    dev_halt_a:
        assert property (development_mode_out |-> wd_halt_out)
        else $error("watchdog runs in debug mode");
    // main scenarios reached
    cover property (mode_out == MODE_SLEEP ##1 mode_out == MODE_RESTART);
    cover property (mode_out == MODE_FAILSAFE);
    cover property ($rose(overvoltage_flag_out));
endmodule
bind sbc_mode_state_machine sbc_mode_chk #(.RESET_DELAY(RESET_DELAY)) sbc_mode_chk_i (
    .clk_in, .sys_rst_in, .spi_cmd_in, .spi_mode_write_in, .spi_mode_in, .wd_fail_in,
    .wd_fail_count_select_in, .overvoltage_reset_enable_in, .wake_in, .overtemp_in,
    .mode_out, .mode_bits_out, .main_supply_en_out, .reset_output_out, .fail_outputs_out,
    .overvoltage_flag_out, .spi_error_flag_out, .config_pin_level_out,
    .development_mode_out, .wd_halt_out);
`default_nettype wire

// File: tb/mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// microcontroller side: spi frames and watchdog trigger
module mcu_model (
    input wire logic clk_in, // clock
    input wire logic sys_rst_in, // power-on reset
    input wire logic reset_output_in, // reset from device
    output logic spi_cmd_out, // frame done
    output logic spi_mode_write_out, // mode write
    output logic [1:0] spi_mode_out, // mode asked
    output logic wd_trigger_out, // wd trigger
    output logic power_on_flag_out // power-on flag
);
    // idle levels
    initial begin
        spi_cmd_out = 1'b0;
        spi_mode_write_out = 1'b0;
        spi_mode_out = 2'h0;
        wd_trigger_out = 1'b0;
        power_on_flag_out = 1'b1;
    end
    // flag set again at power-on
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            power_on_flag_out <= 1'b1;
        end
    end
    task automatic send(input logic [1:0] m, input logic w, input int gap);
        // held in reset the mcu cannot talk
        while (!reset_output_in) @(negedge clk_in);
        repeat (gap + 1) @(negedge clk_in);
        spi_mode_out = m;
        spi_mode_write_out = w;
        spi_cmd_out = 1'b1;
        wd_trigger_out = 1'b1;
        @(negedge clk_in);
        spi_cmd_out = 1'b0;
        wd_trigger_out = 1'b0;
        spi_mode_out = ~m;
        spi_mode_write_out = ~w;
        if (reset_output_in) begin
            power_on_flag_out = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sbc_mode_pkg::*;
;
    logic clk_in, sys_rst_in, wd_fail_in, wd_fail_count_select_in, overvoltage_reset_enable_in;
    logic overvoltage_in, undervoltage_in, wake_in, overtemp_in, fail3_debug_pin_in;
    logic config_sense_pin_in, toggle;
    logic spi_cmd_in, spi_mode_write_in, wd_trigger_in, power_on_flag_in;
    logic [1:0] spi_mode_in, mode_bits_out;
    logic [2:0] mode_out;
    logic main_supply_en_out, reset_output_out, fail_outputs_out, overvoltage_flag_out;
    logic spi_error_flag_out, config_pin_level_out, wd_fail_count_select_out;
    logic development_mode_out, wd_halt_out;
    logic config_pull_down_out, wd_long_window_out;
    int errors, tests_run;
    sbc_mode_state_machine #(.LONG_WINDOW(50), .RESET_DELAY(12), .FILTER_CYCLES(4))
        sbc_mode_state_machine_i (.clk_in, .sys_rst_in, .spi_cmd_in, .spi_mode_write_in,
        .spi_mode_in, .wd_trigger_in, .wd_fail_in, .wd_fail_count_select_in,
        .overvoltage_reset_enable_in, .overvoltage_in, .undervoltage_in, .wake_in,
        .overtemp_in, .power_on_flag_in, .fail3_debug_pin_in, .config_sense_pin_in,
        .mode_out, .mode_bits_out, .main_supply_en_out, .reset_output_out,
        .fail_outputs_out, .overvoltage_flag_out, .spi_error_flag_out,
        .config_pull_down_out, .config_pin_level_out, .wd_fail_count_select_out,
        .development_mode_out, .wd_long_window_out, .wd_halt_out);
    mcu_model mcu_model_i (.clk_in, .sys_rst_in, .reset_output_in(reset_output_out),
        .spi_cmd_out(spi_cmd_in), .spi_mode_write_out(spi_mode_write_in),
        .spi_mode_out(spi_mode_in), .wd_trigger_out(wd_trigger_in),
        .power_on_flag_out(power_on_flag_in));
    // 200 mhz clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // sense pin with no stable level
    always @(negedge clk_in) begin
        if (toggle) begin
            config_sense_pin_in <= ~config_sense_pin_in;
        end
    end
    task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rst(input logic c, input logic d, input logic t);
        config_sense_pin_in = c;
        fail3_debug_pin_in = d;
        toggle = t;
        sys_rst_in = 1'b1;
        repeat (12) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask
    task automatic wait_mode(input logic [2:0] m, input int n);
        for (int i = 0; i < n && mode_out !== m; i++) begin
            @(negedge clk_in);
        end
    endtask
    task automatic pulse(input logic w);
        wake_in = w;
        wd_fail_in = !w;
        @(negedge clk_in);
        wake_in = 1'b0;
        wd_fail_in = 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (5000) @(posedge clk_in);
        errors++;
        stop_test();
    end
    // scenarios
    initial begin
        {wd_fail_in, overvoltage_reset_enable_in, overvoltage_in, undervoltage_in} = 4'h0;
        {wake_in, overtemp_in} = 2'h0;
        wd_fail_count_select_in = 1'b1;
        rst(1'b1, 1'b1, 1'b0);
        check("mode", mode_out, MODE_INIT);
        check("pd", config_pull_down_out, 1'b1);
        check("lw", wd_long_window_out, 1'b1);
        mcu_model_i.send(REQ_SLEEP, 1'b1, 0);
        check("mode", mode_out, MODE_NORMAL);
        check("pd", config_pull_down_out, 1'b0);
        check("lw", wd_long_window_out, 1'b0);
        check("cfg", config_pin_level_out, 1'b1);
        check("dev", development_mode_out, 1'b0);
        check("sel", wd_fail_count_select_out, 1'b1);
        mcu_model_i.send(REQ_STOP, 1'b1, 3);
        check("mode", mode_out, MODE_STOP);
        check("supply", main_supply_en_out, 1'b1);
        mcu_model_i.send(REQ_NORMAL, 1'b1, 0);
        check("mode", mode_out, MODE_NORMAL);
        mcu_model_i.send(REQ_STOP, 1'b1, 0);
        mcu_model_i.send(REQ_SLEEP, 1'b1, 0);
        check("mode", mode_out, MODE_RESTART);
        check("spierr", spi_error_flag_out, 1'b1);
        check("rst", reset_output_out, 1'b0);
        check("bits", mode_bits_out, MODE_BITS_RESET);
        wait_mode(MODE_NORMAL, 20);
        check("mode", mode_out, MODE_NORMAL);
        check("rst", reset_output_out, 1'b1);
        mcu_model_i.send(REQ_SLEEP, 1'b1, 0);
        check("mode", mode_out, MODE_SLEEP);
        check("supply", main_supply_en_out, 1'b0);
        pulse(1'b1);
        check("mode", mode_out, MODE_RESTART);
        wait_mode(MODE_NORMAL, 20);
        overvoltage_in = 1'b1;
        repeat (8) @(negedge clk_in);
        overvoltage_in = 1'b0;
        check("ovf", overvoltage_flag_out, 1'b1);
        check("fail", fail_outputs_out, 1'b0);
        check("mode", mode_out, MODE_NORMAL);
        mcu_model_i.send(REQ_RESET, 1'b1, 0);
        check("mode", mode_out, MODE_INIT);
        wait_mode(MODE_RESTART, 70);
        check("mode", mode_out, MODE_RESTART);
        // second failure sets fail outputs
        wd_fail_count_select_in = 1'b0;
        rst(1'b1, 1'b1, 1'b0);
        mcu_model_i.send(REQ_NORMAL, 1'b0, 0);
        pulse(1'b0);
        check("mode", mode_out, MODE_RESTART);
        check("fail", fail_outputs_out, 1'b0);
        wait_mode(MODE_NORMAL, 20);
        pulse(1'b0);
        check("mode", mode_out, MODE_RESTART);
        check("fail", fail_outputs_out, 1'b1);
        // no pull-up: failure goes to failsafe
        wd_fail_count_select_in = 1'b1;
        rst(1'b0, 1'b1, 1'b0);
        mcu_model_i.send(REQ_NORMAL, 1'b1, 0);
        check("cfg", config_pin_level_out, 1'b0);
        overtemp_in = 1'b1;
        pulse(1'b0);
        check("mode", mode_out, MODE_FAILSAFE);
        check("fail", fail_outputs_out, 1'b1);
        check("supply", main_supply_en_out, 1'b0);
        repeat (10) @(negedge clk_in);
        check("mode", mode_out, MODE_FAILSAFE);
        pulse(1'b1);
        check("mode", mode_out, MODE_RESTART);
        overtemp_in = 1'b0;
        // debug pin low, unstable sense pin
        rst(1'b0, 1'b0, 1'b1);
        mcu_model_i.send(REQ_STOP, 1'b1, 0);
        toggle = 1'b0;
        check("dev", development_mode_out, 1'b1);
        check("halt", wd_halt_out, 1'b1);
        check("cfg", config_pin_level_out, 1'b0);
        mcu_model_i.send(REQ_STOP, 1'b1, 0);
        check("mode", mode_out, MODE_STOP);
        mcu_model_i.send(REQ_NORMAL, 1'b1, 0);
        overtemp_in = 1'b1;
        overvoltage_reset_enable_in = 1'b1;
        overvoltage_in = 1'b1;
        repeat (7) @(negedge clk_in);
        check("mode", mode_out, MODE_FAILSAFE);
        check("fail", fail_outputs_out, 1'b1);
        check("ovf", overvoltage_flag_out, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
